// ==== design/adrt_ctrl.sv ====
/*
 * Converter sequencer with AHB-Lite register slave: repeat mode and
 * delayed trigger mode 1. Assumes an external analog mux, a sample
 * switch and a comparator driven by dac_code; trigger and comparator
 * pins are asynchronous to hclk.
 */
// The implementer's own choices: the register addresses and the AHB-Lite register port.
// Notes on behaviour
// - Repeat mode reconverts one chosen input forever
// - Software trigger: start bit write begins conversion
// - Hardware trigger: falling pin edge after start
// - Repeat stops on start clear, no interrupt
// - Repeat input from any of four groups
// - Result lands in register of its position
// - First trigger edge converts position zero
// - Second input waits for second trigger edge
// - Early second edge remembered during first conversion
// - Edges during later sweep positions are ignored
// - Edge after finished sweep starts new sweep
// - Trigger edges sampled on converter clock
// - Interrupt request when the sweep completes
// - Sweep stops on completion or start clear
// - Sweep width gives 2, 4, 6, 8 inputs
// - Whole sweep stays in one group
`timescale 1ns/1ps
module adrt_ctrl import adrt_pkg::*; #(
	parameter int SAMPLE_CYC = SAMPLE_CYC_DEF,
	parameter int BIT_CYC = BIT_CYC_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	input wire logic external_trigger_pin,
	input wire logic cmp_in,
	output logic [1:0] ain_group,
	output logic [2:0] ain_select,
	output logic sample_en,
	output logic [RES_W-1:0] dac_code,
	output logic conv_irq
);
	// ==========================================================
	// Declarations
	logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
	logic cmp_s1_reg, cmp_s2_reg;
	logic trig_fall;
	logic wr_pend_reg, wr_pend_next;
	logic rd_wait_reg, rd_wait_next;
	logic [7:0] addr_reg, addr_next;
	logic hready_reg, hready_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [1:0] hresp_reg;
	logic acc;
	adrt_cfg_t cfg_reg, cfg_next;
	adrt_state_t state_reg, state_next;
	logic [2:0] pos_reg, pos_next;
	logic edge2_reg, edge2_next;
	logic [7:0] scnt_reg, scnt_next;
	logic irq_reg, irq_next;
	logic samp_reg, samp_next;
	logic [2:0] sel_reg;
	logic [1:0] grp_reg;
	logic [RES_W-1:0] res_reg [NUM_RES];
	logic [RES_W-1:0] res_next [NUM_RES];
	logic [2:0] last_pos;
	logic sar_start, sar_abort, sar_done;
	logic [RES_W-1:0] sar_result;

	// ==========================================================
	// Pin synchronisers
	// edge sampling
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_s1_reg <= 1'b1;
			trig_s2_reg <= 1'b1;
			trig_s3_reg <= 1'b1;
			cmp_s1_reg <= 1'b0;
			cmp_s2_reg <= 1'b0;
		end else begin
			trig_s1_reg <= external_trigger_pin;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
			cmp_s1_reg <= cmp_in;
			cmp_s2_reg <= cmp_s1_reg;
		end
	end
	assign trig_fall = trig_s3_reg & ~trig_s2_reg;

	// ==========================================================
	// AHB-Lite slave
	assign acc = hsel & hready & (htrans == HTRANS_NONSEQ);

	always_comb begin
		logic [31:0] rd;
		rd = '0;
		wr_pend_next = acc & hwrite;
		rd_wait_next = acc & ~hwrite;
		addr_next = acc ? haddr[7:0] : addr_reg;
		hready_next = ~(acc & ~hwrite);
		case (addr_reg)
			ADDR_CTL0: begin
				rd[CTL0_CH_LSB+:3] = cfg_reg.ch;
				rd[CTL0_TRG] = cfg_reg.trigger_source_bit;
				rd[CTL0_START] = cfg_reg.start;
			end
			ADDR_CTL1: begin
				rd[CTL1_MODE] = cfg_reg.mode;
				rd[CTL1_SWEEP_LSB+:2] = cfg_reg.sweep;
			end
			ADDR_CTL2: rd[CTL2_GRP_LSB+:2] = cfg_reg.group;
			ADDR_STAT: begin
				rd[STAT_BUSY] = (state_reg != S_IDLE);
				rd[STAT_POS_LSB+:3] = pos_reg;
				rd[STAT_WAIT2] = (state_reg == S_WAIT2);
			end
			default: begin
				if (addr_reg[7:5] == RES_PAGE && addr_reg[1:0] == 2'h0) begin
					rd[RES_W-1:0] = res_reg[addr_reg[4:2]];
				end
			end
		endcase
		hrdata_next = rd_wait_reg ? rd : hrdata_reg;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			addr_reg <= 8'h00;
			hready_reg <= 1'b1;
			hrdata_reg <= 32'h00000000;
			hresp_reg <= HRESP_OKAY;
		end else begin
			wr_pend_reg <= wr_pend_next;
			rd_wait_reg <= rd_wait_next;
			addr_reg <= addr_next;
			hready_reg <= hready_next;
			hrdata_reg <= hrdata_next;
			hresp_reg <= HRESP_OKAY;
		end
	end

	// ==========================================================
	// Sequencer and configuration
	// sweep of 2w+2
	assign last_pos = {cfg_reg.sweep, 1'b1};

	always_comb begin
		cfg_next = cfg_reg;
		state_next = state_reg;
		pos_next = pos_reg;
		edge2_next = edge2_reg;
		scnt_next = scnt_reg;
		irq_next = 1'b0;
		sar_start = 1'b0;
		sar_abort = 1'b0;
		res_next = res_reg;
		if (wr_pend_reg) begin
			case (addr_reg)
				ADDR_CTL0: begin
					cfg_next.ch = hwdata[CTL0_CH_LSB+:3];
					cfg_next.trigger_source_bit = hwdata[CTL0_TRG];
					if (cfg_reg.mode == MODE_DT1) begin
						cfg_next.start = cfg_reg.start & hwdata[CTL0_START];
					end else begin
						cfg_next.start = hwdata[CTL0_START];
					end
				end
				ADDR_CTL1: begin
					cfg_next.mode = hwdata[CTL1_MODE];
					cfg_next.sweep = hwdata[CTL1_SWEEP_LSB+:2];
				end
				ADDR_CTL2: cfg_next.group = hwdata[CTL2_GRP_LSB+:2];
				default: begin
				end
			endcase
		end
		if (!cfg_reg.start && state_reg != S_IDLE) begin
			state_next = S_IDLE;
			edge2_next = 1'b0;
			sar_abort = 1'b1;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (cfg_reg.mode == MODE_DT1) begin
						if (trig_fall) begin
							cfg_next.start = 1'b1;
							pos_next = 3'h0;
							edge2_next = 1'b0;
							scnt_next = 8'h00;
							state_next = S_SAMP;
						end
					end else if (cfg_reg.start) begin
						pos_next = cfg_reg.ch;
						scnt_next = 8'h00;
						state_next = cfg_reg.trigger_source_bit ? S_ARM : S_SAMP;
					end
				end
				S_ARM: begin
					if (trig_fall) begin
						state_next = S_SAMP;
					end
				end
				S_SAMP: begin
					if (scnt_reg == 8'(SAMPLE_CYC - 1)) begin
						sar_start = 1'b1;
						state_next = S_CONV;
					end else begin
						scnt_next = 8'(scnt_reg + 8'h01);
					end
				end
				S_CONV: begin
					if (cfg_reg.mode == MODE_DT1 && pos_reg == 3'h0 &&
					    trig_fall) begin
						edge2_next = 1'b1;
					end
					if (sar_done) begin
						res_next[pos_reg] = sar_result;
						scnt_next = 8'h00;
						if (cfg_reg.mode == MODE_REPEAT) begin
							pos_next = cfg_reg.ch;
							state_next = S_SAMP;
						end else if (pos_reg == last_pos) begin
							cfg_next.start = 1'b0;
							irq_next = 1'b1;
							state_next = S_IDLE;
						end else if (pos_reg == 3'h0 &&
						             !(edge2_reg | trig_fall)) begin
							state_next = S_WAIT2;
						end else begin
							pos_next = 3'(pos_reg + 3'h1);
							state_next = S_SAMP;
						end
					end
				end
				S_WAIT2: begin
					if (trig_fall) begin
						pos_next = 3'h1;
						scnt_next = 8'h00;
						state_next = S_SAMP;
					end
				end
				default: state_next = S_IDLE;
			endcase
		end
		samp_next = (state_next == S_SAMP);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg <= CFG_RST;
			state_reg <= S_IDLE;
			pos_reg <= 3'h0;
			edge2_reg <= 1'b0;
			scnt_reg <= 8'h00;
			irq_reg <= 1'b0;
			samp_reg <= 1'b0;
			sel_reg <= 3'h0;
			grp_reg <= 2'h0;
			for (int i = 0; i < NUM_RES; i++) begin
				res_reg[i] <= '0;
			end
		end else begin
			cfg_reg <= cfg_next;
			state_reg <= state_next;
			pos_reg <= pos_next;
			edge2_reg <= edge2_next;
			scnt_reg <= scnt_next;
			irq_reg <= irq_next;
			samp_reg <= samp_next;
			sel_reg <= pos_next;
			grp_reg <= cfg_next.group;
			res_reg <= res_next;
		end
	end

	// ==========================================================
	// Converter engine
	adrt_sar #(
		.RES_W_P(RES_W),
		.BIT_CYC_P(BIT_CYC)
	) u_sar (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(sar_start),
		.abort(sar_abort),
		.cmp_hi(cmp_s2_reg),
		.done(sar_done),
		.result(sar_result),
		.dac_code(dac_code)
	);

	assign hreadyout = hready_reg;
	assign hresp = hresp_reg;
	assign hrdata = hrdata_reg;
	assign ain_group = grp_reg;
	assign ain_select = sel_reg;
	assign sample_en = samp_reg;
	assign conv_irq = irq_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_dt1_conv;
		cfg_reg.mode == MODE_DT1 && state_reg == S_CONV && cfg_reg.start;
	endsequence
	sequence s_rep_done;
		cfg_reg.mode == MODE_REPEAT && state_reg == S_CONV &&
		cfg_reg.start && sar_done;
	endsequence

	AST_REPEAT_AGAIN: assert property (
		s_rep_done |=> state_reg == S_SAMP && pos_reg == $past(cfg_reg.ch))
		else $error("repeat mode did not resample");
	AST_SW_START: assert property (
		state_reg == S_IDLE && cfg_reg.mode == MODE_REPEAT &&
		cfg_reg.start && !cfg_reg.trigger_source_bit |=> state_reg == S_SAMP ##1 sample_en)
		else $error("software start not taken");
	AST_HW_WAIT: assert property (
		state_reg == S_ARM && cfg_reg.start && !trig_fall |=>
		state_reg == S_ARM && !sample_en)
		else $error("hardware start without edge");
	AST_NO_IRQ_REPEAT: assert property (
		conv_irq |-> $past(cfg_reg.mode) == MODE_DT1)
		else $error("interrupt in repeat mode");
	AST_STOP: assert property (
		!cfg_reg.start && state_reg != S_IDLE |=> state_reg == S_IDLE)
		else $error("start clear did not stop");
	AST_RESULT: assert property (
		state_reg == S_CONV && cfg_reg.start && sar_done |=>
		res_reg[$past(pos_reg)] == $past(sar_result))
		else $error("result not stored");
	AST_FIRST_EDGE: assert property (
		state_reg == S_IDLE && cfg_reg.mode == MODE_DT1 && trig_fall |=>
		state_reg == S_SAMP && pos_reg == 3'h0 && cfg_reg.start)
		else $error("first edge did not start sweep");
	AST_WAIT2_HOLD: assert property (
		state_reg == S_WAIT2 && cfg_reg.start && !trig_fall |=>
		state_reg == S_WAIT2 [*1] ##0 !sample_en)
		else $error("second input started early");
	AST_EARLY_EDGE: assert property (
		s_dt1_conv ##0 pos_reg == 3'h0 && trig_fall && !sar_done |=>
		edge2_reg)
		else $error("early second edge lost");
	AST_IGNORE_EDGE: assert property (
		s_dt1_conv ##0 pos_reg != 3'h0 && !sar_done |=>
		$stable(pos_reg) && state_reg == S_CONV)
		else $error("later edge disturbed sweep");
	AST_SWEEP_IRQ: assert property (
		s_dt1_conv ##0 sar_done && pos_reg == last_pos |=>
		conv_irq && state_reg == S_IDLE && !cfg_reg.start)
		else $error("sweep end without interrupt");
endmodule

// ==== design/adrt_pkg.sv ====
/*
 * Constants, register map and types for the repeat / delayed trigger
 * converter controller. Assumes a single 40 MHz clock domain.
 */
package adrt_pkg;
	// ==========================================================
	// Register map (byte offsets)
	localparam logic [7:0] ADDR_CTL0 = 8'h00;
	localparam logic [7:0] ADDR_CTL1 = 8'h04;
	localparam logic [7:0] ADDR_CTL2 = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [2:0] RES_PAGE = 3'h1;
	// ==========================================================
	// Field positions
	localparam int CTL0_CH_LSB = 0;
	localparam int CTL0_TRG = 3;
	localparam int CTL0_START = 4;
	localparam int CTL1_MODE = 0;
	localparam int CTL1_SWEEP_LSB = 1;
	localparam int CTL2_GRP_LSB = 0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_POS_LSB = 1;
	localparam int STAT_WAIT2 = 4;
	// ==========================================================
	// Sizes, timing and encodings
	localparam int RES_W = 10;
	localparam int NUM_RES = 8;
	localparam int SAMPLE_CYC_DEF = 4;
	localparam int BIT_CYC_DEF = 4;
	localparam logic MODE_REPEAT = 1'b0;
	localparam logic MODE_DT1 = 1'b1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		S_IDLE,
		S_ARM,
		S_SAMP,
		S_CONV,
		S_WAIT2
	} adrt_state_t;
	typedef struct packed {
		logic mode;
		logic [1:0] sweep;
		logic [1:0] group;
		logic trigger_source_bit;
		logic start;
		logic [2:0] ch;
	} adrt_cfg_t;
	localparam adrt_cfg_t CFG_RST = '0;
endpackage

// ==== design/adrt_sar.sv ====
/*
 * Successive approximation engine: one bit per BIT_CYC_P clocks.
 * Assumes cmp_hi is already synchronised and reflects the analog
 * input being at or above dac_code.
 */
`timescale 1ns/1ps
module adrt_sar import adrt_pkg::*; #(
	parameter int RES_W_P = RES_W,
	parameter int BIT_CYC_P = BIT_CYC_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic abort,
	input wire logic cmp_hi,
	output logic done,
	output logic [RES_W_P-1:0] result,
	output logic [RES_W_P-1:0] dac_code
);
	localparam int IDX_W = $clog2(RES_W_P);
	logic run_reg, run_next;
	logic [IDX_W-1:0] idx_reg, idx_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [RES_W_P-1:0] code_reg, code_next;
	logic [RES_W_P-1:0] result_reg, result_next;
	logic done_reg, done_next;

	// ==========================================================
	// Bit stepping
	always_comb begin
		run_next = run_reg;
		idx_next = idx_reg;
		cnt_next = cnt_reg;
		code_next = code_reg;
		result_next = result_reg;
		done_next = 1'b0;
		if (abort) begin
			run_next = 1'b0;
		end else if (start) begin
			run_next = 1'b1;
			idx_next = IDX_W'(RES_W_P - 1);
			cnt_next = 8'h00;
			code_next = '0;
			code_next[RES_W_P-1] = 1'b1;
		end else if (run_reg) begin
			if (cnt_reg == 8'(BIT_CYC_P - 1)) begin
				cnt_next = 8'h00;
				if (!cmp_hi) begin
					code_next[idx_reg] = 1'b0;
				end
				if (idx_reg == '0) begin
					run_next = 1'b0;
					done_next = 1'b1;
					result_next = code_next;
				end else begin
					idx_next = IDX_W'(idx_reg - 1'b1);
					code_next[idx_next] = 1'b1;
				end
			end else begin
				cnt_next = 8'(cnt_reg + 8'h01);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_reg <= 1'b0;
			idx_reg <= '0;
			cnt_reg <= 8'h00;
			code_reg <= '0;
			result_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
			idx_reg <= idx_next;
			cnt_reg <= cnt_next;
			code_reg <= code_next;
			result_reg <= result_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;
	assign result = result_reg;
	assign dac_code = code_reg;
endmodule

// ==== dv/adrt_far_model.sv ====
/*
 * Far-side model: analog inputs behind the mux and the trigger source.
 * Assumes the controller drives group, position and trial code.
 */
`timescale 1ns/1ps
module adrt_far_model import adrt_pkg::*; (
	input wire logic hclk,
	input wire logic [1:0] ain_group,
	input wire logic [2:0] ain_select,
	input wire logic [RES_W-1:0] dac_code,
	input wire logic fire,
	input wire logic [4:0] ofs,
	output logic external_trigger_pin,
	output logic cmp_in
);
	logic [2:0] low_cnt = 3'h0;
	logic pin_q = 1'b1;
	// ========
	// Analog level of the selected input
	always_comb cmp_in = {ain_group, ain_select, ofs} >= dac_code;
	// ========
	// Trigger pin, low three clocks per request
	assign external_trigger_pin = pin_q;
	always @(posedge hclk) begin
		if (fire)
			low_cnt <= 3'h3;
		else if (low_cnt != 3'h0)
			low_cnt <= low_cnt - 3'h1;
		pin_q <= ~(fire | (low_cnt > 3'h1));
	end
endmodule

// ==== dv/test_adc_repeat_delayed_trigger_ctrl.sv ====
/*
 * Self-checking bench for the converter controller.
 * Assumes the far-side model and the AHB-Lite slave of adrt_ctrl.
 */
`timescale 1ns/1ps
module test_adc_repeat_delayed_trigger_ctrl import adrt_pkg::*; ;
	typedef struct packed {
		adrt_cfg_t cfg;
		logic [3:0] n_in;
	} adrt_row_t;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic fire = 1'b0;
	logic samp_q = 1'b0;
	logic hreadyout, ext_trig, cmp, smp, irq;
	logic [1:0] hresp, grp;
	logic [2:0] sel;
	logic [31:0] hrdata, q;
	logic [RES_W-1:0] dac;
	logic [4:0] ofs = 5'h0a;
	int n_errors = 0, n_tests = 0, n_irq = 0, n_samp = 0, k0, s0;
	adrt_row_t rows [7];
	adrt_row_t r;
	always #12.5 hclk = ~hclk;
	adrt_ctrl #(.SAMPLE_CYC(SAMPLE_CYC_DEF), .BIT_CYC(BIT_CYC_DEF)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .external_trigger_pin(ext_trig), .cmp_in(cmp),
		.ain_group(grp), .ain_select(sel), .sample_en(smp),
		.dac_code(dac), .conv_irq(irq));
	adrt_far_model far_u (.hclk(hclk), .ain_group(grp), .ain_select(sel),
		.dac_code(dac), .fire(fire), .ofs(ofs),
		.external_trigger_pin(ext_trig), .cmp_in(cmp));
	always @(posedge hclk) begin
		samp_q <= smp;
		if (irq === 1'b1)
			n_irq <= n_irq + 1;
		if (smp === 1'b1 && samp_q !== 1'b1)
			n_samp <= n_samp + 1;
	end
	// ========
	// Bus and check tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, exp);
		bus(1'b0, a, 32'h0);
		chk(q & m, exp);
	endtask
	task automatic trig();
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (8) @(posedge hclk);
	endtask
	task automatic wait_wait2();
		int k;
		k = 0;
		do begin
			bus(1'b0, ADDR_STAT, 32'h0);
			k++;
		end while (q[STAT_WAIT2] !== 1'b1 && k < 100);
	endtask
	task automatic wait_irq(input int tgt);
		int k;
		k = 0;
		while (n_irq < tgt && k < 3000) begin
			@(posedge hclk);
			k++;
		end
		chk(32'(n_irq), 32'(tgt));
	endtask
	function automatic logic [31:0] ev(input logic [1:0] g, logic [2:0] p);
		return {22'h0, g, p, ofs};
	endfunction
	task automatic res(input logic [1:0] g, input logic [3:0] n);
		for (int p = 0; p < n; p++)
			rdc(8'h20 + 8'(4 * p), 32'h3ff, ev(g, 3'(p)));
	endtask
	task automatic final_report();
		$display("TB: %0d errors in %0d checks", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		n_errors++;
		final_report();
	end
	// ========
	// Main sequence
	initial begin
		rows[0] = '{'{MODE_DT1, 2'h0, 2'h0, 1'b0, 1'b0, 3'h0}, 4'h2};
		rows[1] = '{'{MODE_DT1, 2'h1, 2'h1, 1'b0, 1'b0, 3'h0}, 4'h4};
		rows[2] = '{'{MODE_DT1, 2'h2, 2'h2, 1'b0, 1'b0, 3'h0}, 4'h6};
		rows[3] = '{'{MODE_DT1, 2'h3, 2'h3, 1'b0, 1'b0, 3'h0}, 4'h8};
		rows[4] = '{'{MODE_REPEAT, 2'h0, 2'h0, 1'b0, 1'b0, 3'h5}, 4'h1};
		rows[5] = '{'{MODE_REPEAT, 2'h0, 2'h3, 1'b0, 1'b0, 3'h2}, 4'h1};
		rows[6] = '{'{MODE_REPEAT, 2'h0, 2'h1, 1'b1, 1'b0, 3'h7}, 4'h1};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(ADDR_CTL0, 32'hffffffff, 32'h0);
		rdc(ADDR_CTL1, 32'hffffffff, 32'h0);
		chk(32'(hresp), 32'(HRESP_OKAY));
		for (int i = 0; i < 7; i++) begin
			r = rows[i];
			wr(ADDR_CTL2, 32'(r.cfg.group));
			wr(ADDR_CTL1, 32'({r.cfg.sweep, r.cfg.mode}));
			k0 = n_irq;
			if (r.cfg.mode == MODE_DT1) begin
				trig();
				wait_wait2();
				chk(32'(q[STAT_WAIT2]), 32'h1);
				s0 = n_samp;
				repeat (30) @(posedge hclk);
				chk(32'(n_samp - s0), 32'h0);
				rdc(8'h20, 32'h3ff, ev(r.cfg.group, 3'h0));
				trig();
				wait_irq(k0 + 1);
				res(r.cfg.group, r.n_in);
				rdc(ADDR_STAT, 32'h1, 32'h0);
			end else begin
				s0 = n_samp;
				wr(ADDR_CTL0, 32'({r.cfg.trigger_source_bit, r.cfg.ch}) | 32'h10);
				if (r.cfg.trigger_source_bit) begin
					repeat (60) @(posedge hclk);
					chk(32'(n_samp - s0), 32'h0);
					trig();
				end
				repeat (150) @(posedge hclk);
				rdc(8'h20 + 8'(4 * r.cfg.ch), 32'h3ff,
					ev(r.cfg.group, r.cfg.ch));
				ofs <= 5'h15;
				repeat (150) @(posedge hclk);
				rdc(8'h20 + 8'(4 * r.cfg.ch), 32'h3ff,
					ev(r.cfg.group, r.cfg.ch));
				wr(ADDR_CTL0, 32'(r.cfg.ch));
				repeat (60) @(posedge hclk);
				s0 = n_samp;
				repeat (100) @(posedge hclk);
				chk(32'(n_samp - s0), 32'h0);
				chk(32'(n_irq - k0), 32'h0);
				ofs <= 5'h0a;
			end
		end
		// Early second edge and stray edge mid-sweep
		wr(ADDR_CTL2, 32'h0);
		wr(ADDR_CTL1, 32'h7);
		wr(ADDR_CTL0, 32'h0);
		k0 = n_irq;
		trig();
		trig();
		repeat (90) @(posedge hclk);
		trig();
		wait_irq(k0 + 1);
		res(2'h0, 4'h8);
		repeat (100) @(posedge hclk);
		chk(32'(n_irq - k0), 32'h1);
		rdc(ADDR_STAT, 32'h1, 32'h0);
		// New sweep after completion, then abort
		trig();
		wait_wait2();
		chk(32'(q[STAT_WAIT2]), 32'h1);
		k0 = n_irq;
		wr(ADDR_CTL0, 32'h0);
		repeat (200) @(posedge hclk);
		rdc(ADDR_STAT, 32'h11, 32'h0);
		chk(32'(n_irq - k0), 32'h0);
		// Unmapped offsets and reset while idle
		wr(8'h14, 32'hffffffff);
		rdc(8'h14, 32'hffffffff, 32'h0);
		rdc(8'h40, 32'hffffffff, 32'h0);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(ADDR_CTL1, 32'hffffffff, 32'h0);
		final_report();
	end
endmodule
